// ---- hdl/cam_regs.vh ----
`ifndef CAM_REGS_VH
`define CAM_REGS_VH

// Register offsets on the register port.
`define REG_HOST_COMMAND_WORD   16'h2d02
`define REG_DRIVE_STATUS_WORD   16'h2d12

// Command word fields.
`define CMD_COUPLER_BIT         11
`define CMD_COMP_REQ_BIT        13
`define CMD_RESET_VAL           16'h0000

// Status word fields.
`define STS_CAM_ACTIVE_BIT      0
`define STS_ALARM_BIT           1
`define STS_ENGAGED_BIT         11
`define STS_SMOOTHING_BIT       12
`define STS_COMP_DONE_BIT       13

// Restoration target codes.
`define RESTORE_ONE_CYCLE       2'h0
`define RESTORE_STD_POS         2'h1
`define RESTORE_FEED            2'h2

// Coupler control setting codes.
`define COUPLER_NONE            1'b0
`define COUPLER_CMD             1'b1

// Timing: clock period and internal cycles, in ns.
`define CLOCK_PERIOD_NS         10
`define CTRL_PERIOD_NS          20000
`define SCAN_PERIOD_NS          40000
`define CTRL_CYCLES             (`CTRL_PERIOD_NS / `CLOCK_PERIOD_NS)
`define SCAN_CYCLES             (`SCAN_PERIOD_NS / `CLOCK_PERIOD_NS)
`define CTRL_LAST               16'h07cf
`define SCAN_LAST               16'h0f9f

`endif

// ---- hdl/coupler_smoother.v ----
`default_nettype none

// Exponential smoothing of the per-cycle command increment. Whatever is not
// yet passed on stays in the residual, so total travel is preserved.
module coupler_smoother (
	// Clock and reset
	input  wire               clock,
	input  wire               rst,
	// Control
	input  wire               tick,
	input  wire               bypass,
	input  wire [3:0]         tc_shift,
	// Data
	input  wire signed [31:0] in_delta,
	output reg  signed [31:0] out_delta,
	output wire               busy
);

	reg  signed [31:0] residual_q;
	wire signed [31:0] residual_sum;
	reg  signed [31:0] step;

	assign residual_sum = residual_q + in_delta;
	assign busy         = (residual_q != 32'sh0000_0000);

	always @* begin
		step = residual_sum >>> tc_shift;
		if (step == 32'sh0000_0000 && residual_sum != 32'sh0000_0000) begin
			step = residual_sum[31] ? -32'sh0000_0001 : 32'sh0000_0001;
		end
	end

	always @(posedge clock) begin
		if (rst) begin
			residual_q <= 32'sh0000_0000;
			out_delta  <= 32'sh0000_0000;
		end else if (tick) begin
			if (bypass) begin
				residual_q <= 32'sh0000_0000;
				out_delta  <= in_delta;
			end else begin
				residual_q <= residual_sum - step;
				out_delta  <= step;
			end
		end
	end

endmodule // coupler_smoother

`default_nettype wire

// ---- hdl/comp_spreader.v ----
`default_nettype none

// Spreads a compensation amount over 2^tc_shift control cycles.
module comp_spreader (
	// Clock and reset
	input  wire               clock,
	input  wire               rst,
	// Control
	input  wire               tick,
	input  wire               start,
	input  wire [3:0]         tc_shift,
	input  wire signed [31:0] amount,
	// Result
	output reg  signed [31:0] step_out,
	output reg                active,
	output reg                done
);

	reg  signed [31:0] left_q;
	reg  signed [31:0] slice_q;
	reg  [15:0]        count_q;
	reg                last_q;

	always @(posedge clock) begin
		if (rst) begin
			left_q   <= 32'sh0000_0000;
			slice_q  <= 32'sh0000_0000;
			count_q  <= 16'h0000;
			step_out <= 32'sh0000_0000;
			active   <= 1'b0;
			done     <= 1'b0;
			last_q   <= 1'b0;
		end else if (start) begin
			left_q   <= amount;
			slice_q  <= amount >>> tc_shift;
			count_q  <= 16'h0001 << tc_shift;
			step_out <= 32'sh0000_0000;
			active   <= 1'b1;
			done     <= 1'b0;
			last_q   <= 1'b0;
		end else begin
			step_out <= 32'sh0000_0000;
			last_q   <= 1'b0;
			// Done rises a cycle after the last slice, once the position holds it.
			if (last_q) begin
				done <= 1'b1;
			end
			if (tick && active) begin
				if (count_q == 16'h0001) begin
					step_out <= left_q; // Last slice carries the remainder.
					left_q   <= 32'sh0000_0000;
					active   <= 1'b0;
					last_q   <= 1'b1;
				end else begin
					step_out <= slice_q;
					left_q   <= left_q - slice_q;
				end
				count_q <= count_q - 16'h0001;
			end
		end
	end

endmodule // comp_spreader

`default_nettype wire

// ---- hdl/cam_restore_clutch_compensation.v ----
// Behaviour
// - Restoration target chosen by data code 0/1/2.
// - Standard position restored, then cam control entered.
// - Uses data one-cycle value, feed value at switch-on.
// - Feed value restored from one-cycle and standard position.
// - Feed value jumps to restored value after switching.
// - Gap over in-position range raises alarm, refuses entry.
// - Status bits 11 engaged, 12 smoothing.
// - Engaged coupler passes main-shaft pulses, else blocks.
// - Setting change 1 to 0 refused during cam.
// - On and off in one scan both execute.
// - Setting 0 couples directly, ignores other parameters.
// - Command mode follows command level.
// - Time constant smooths engage, disengage, speed changes.
// - Smoothing keeps total travel unchanged.
// - Setting 1 selects exponential smoothing curve.
// - Compensation drives one-cycle value to target.
// - Request bit 13, completion status bit 13.
// - Amount computed at request, spread over time constant.

`include "cam_regs.vh"

`default_nettype none

module cam_restore_clutch_compensation (
	// Clock and reset
	input  wire               clock,
	input  wire               rst,
	// Register port
	input  wire [15:0]        reg_addr,
	input  wire [15:0]        reg_wdata,
	input  wire               reg_we,
	input  wire               reg_re,
	output reg  [15:0]        reg_rdata,
	// Discrete inputs
	input  wire               cam_ctrl_cmd,
	input  wire               main_shaft_coupler_cmd,
	input  wire               ms_pulse,
	input  wire               ms_dir,
	// Cam control data
	input  wire [1:0]         restore_target,
	input  wire signed [31:0] std_pos_data,
	input  wire signed [31:0] one_cycle_data,
	input  wire [31:0]        inposition_range_setting,
	input  wire               coupler_mode_set,
	input  wire               smoothing_system,
	input  wire [3:0]         coupler_tc_shift,
	input  wire signed [31:0] comp_target,
	input  wire [3:0]         comp_tc_shift,
	// Positions and status
	output reg  signed [31:0] feed_pos,
	output reg  signed [31:0] one_cycle_pos,
	output reg  signed [31:0] std_pos,
	output reg  signed [31:0] axis_delta,
	output reg                cam_active,
	output reg                feed_value_restore_fail_alarm,
	output reg                coupler_engaged_flag,
	output wire               coupler_smoothing_flag,
	output wire               comp_done_flag
);

	// Dividers for control cycle and DI scan cycle.
	reg  [15:0] ctrl_cnt_q;
	reg  [15:0] scan_cnt_q;
	wire        ctrl_tick;
	wire        scan_tick;

	assign ctrl_tick = (ctrl_cnt_q == `CTRL_LAST);
	assign scan_tick = (scan_cnt_q == `SCAN_LAST);

	always @(posedge clock) begin
		if (rst) begin
			ctrl_cnt_q <= 16'h0000;
			scan_cnt_q <= 16'h0000;
		end else begin
			ctrl_cnt_q <= ctrl_tick ? 16'h0000 : ctrl_cnt_q + 16'h0001;
			scan_cnt_q <= scan_tick ? 16'h0000 : scan_cnt_q + 16'h0001;
		end
	end

	// Pin synchronisers: first stage feeds only the second.
	reg  [3:0] pin_s1_q;
	reg  [3:0] pin_s2_q;
	reg        cam_prev_q;
	reg        pulse_prev_q;

	always @(posedge clock) begin
		if (rst) begin
			pin_s1_q     <= 4'h0;
			pin_s2_q     <= 4'h0;
			cam_prev_q   <= 1'b0;
			pulse_prev_q <= 1'b0;
		end else begin
			pin_s1_q     <= {ms_dir, ms_pulse, main_shaft_coupler_cmd, cam_ctrl_cmd};
			pin_s2_q     <= pin_s1_q;
			cam_prev_q   <= pin_s2_q[0];
			pulse_prev_q <= pin_s2_q[2];
		end
	end

	wire cam_rise   = pin_s2_q[0] & ~cam_prev_q;
	wire cam_fall   = ~pin_s2_q[0] & cam_prev_q;
	wire pulse_edge = pin_s2_q[2] & ~pulse_prev_q;

	// Host command word.
	reg  [15:0] cmd_q;
	reg         comp_req_prev_q;
	wire        cmd_wr = reg_we && (reg_addr == `REG_HOST_COMMAND_WORD);

	always @(posedge clock) begin
		if (rst) begin
			cmd_q <= `CMD_RESET_VAL;
		end else if (cmd_wr) begin
			cmd_q <= reg_wdata;
		end
	end

	// Coupler setting; change from command mode to none refused in cam control.
	reg mode_q;

	always @(posedge clock) begin
		if (rst) begin
			mode_q <= `COUPLER_NONE;
		end else if (!(cam_active && mode_q == `COUPLER_CMD &&
				coupler_mode_set == `COUPLER_NONE)) begin
			mode_q <= coupler_mode_set;
		end
	end

	// Coupler command level from the pin or the command word.
	wire coupler_level = pin_s2_q[1] | cmd_q[`CMD_COUPLER_BIT];
	reg  level_prev_q;
	reg  on_seen_q;
	reg  off_seen_q;
	reg  [1:0] seq_q;
	wire on_now  = coupler_level & ~level_prev_q;
	wire off_now = ~coupler_level & level_prev_q;

	always @(posedge clock) begin
		if (rst) begin
			level_prev_q         <= 1'b0;
			on_seen_q            <= 1'b0;
			off_seen_q           <= 1'b0;
			seq_q                <= 2'h0;
			coupler_engaged_flag <= 1'b0;
		end else begin
			level_prev_q <= coupler_level;
			if (mode_q == `COUPLER_NONE) begin
				on_seen_q            <= 1'b0;
				off_seen_q           <= 1'b0;
				seq_q                <= 2'h0;
				coupler_engaged_flag <= 1'b1;
			end else if (seq_q == 2'h2) begin
				seq_q                <= 2'h1;
				coupler_engaged_flag <= 1'b1;
			end else if (seq_q == 2'h1) begin
				seq_q                <= 2'h0;
				coupler_engaged_flag <= 1'b0;
			end else if (scan_tick) begin
				on_seen_q  <= 1'b0;
				off_seen_q <= 1'b0;
				if ((on_seen_q | on_now) && (off_seen_q | off_now)) begin
					coupler_engaged_flag <= ~coupler_engaged_flag;
					seq_q                <= coupler_engaged_flag ? 2'h2 : 2'h1;
				end else begin
					coupler_engaged_flag <= coupler_level;
				end
			end else begin
				on_seen_q  <= on_seen_q | on_now;
				off_seen_q <= off_seen_q | off_now;
			end
		end
	end

	// Main-shaft pulse count per control cycle.
	reg  signed [31:0] ms_count_q;
	wire signed [31:0] pulse_inc = !pulse_edge ? 32'sh0000_0000 :
		(pin_s2_q[3] ? -32'sh0000_0001 : 32'sh0000_0001);
	wire signed [31:0] ms_total = ms_count_q + pulse_inc;

	always @(posedge clock) begin
		if (rst) begin
			ms_count_q <= 32'sh0000_0000;
		end else begin
			ms_count_q <= ctrl_tick ? 32'sh0000_0000 : ms_total;
		end
	end

	wire signed [31:0] gated_delta = coupler_engaged_flag ? ms_total : 32'sh0000_0000;
	wire signed [31:0] smooth_delta;
	wire               smooth_busy;

	coupler_smoother u_smoother (
		.clock     (clock),
		.rst       (rst),
		.tick      (ctrl_tick),
		.bypass    (mode_q == `COUPLER_NONE || !smoothing_system),
		.tc_shift  (coupler_tc_shift),
		.in_delta  (gated_delta),
		.out_delta (smooth_delta),
		.busy      (smooth_busy)
	);

	assign coupler_smoothing_flag = smooth_busy & (mode_q == `COUPLER_CMD);

	// Cam position compensation.
	wire               comp_req   = cmd_q[`CMD_COMP_REQ_BIT];
	wire               comp_start = comp_req & ~comp_req_prev_q & cam_active;
	wire signed [31:0] comp_step;
	wire               comp_busy;

	always @(posedge clock) begin
		if (rst) begin
			comp_req_prev_q <= 1'b0;
		end else begin
			comp_req_prev_q <= comp_req;
		end
	end

	comp_spreader u_comp (
		.clock    (clock),
		.rst      (rst),
		.tick     (ctrl_tick),
		.start    (comp_start),
		.tc_shift (comp_tc_shift),
		.amount   (comp_target - one_cycle_pos),
		.step_out (comp_step),
		.active   (comp_busy),
		.done     (comp_done_flag)
	);

	// Restoration and position tracking.
	wire signed [31:0] restored_feed = std_pos_data + one_cycle_data;
	wire signed [31:0] gap           = restored_feed - feed_pos;
	wire        [31:0] gap_abs       = gap[31] ? (~gap + 32'sh0000_0001) : gap;
	wire               gap_bad       = gap_abs > inposition_range_setting;

	always @(posedge clock) begin
		if (rst) begin
			feed_pos                      <= 32'sh0000_0000;
			one_cycle_pos                 <= 32'sh0000_0000;
			std_pos                       <= 32'sh0000_0000;
			axis_delta                    <= 32'sh0000_0000;
			cam_active                    <= 1'b0;
			feed_value_restore_fail_alarm <= 1'b0;
		end else if (cam_rise) begin
			feed_value_restore_fail_alarm <= 1'b0;
			case (restore_target)
				`RESTORE_ONE_CYCLE: begin
					std_pos       <= std_pos_data;
					one_cycle_pos <= feed_pos - std_pos_data;
					cam_active    <= 1'b1;
				end
				`RESTORE_STD_POS: begin
					one_cycle_pos <= one_cycle_data;
					std_pos       <= feed_pos - one_cycle_data;
					cam_active    <= 1'b1;
				end
				`RESTORE_FEED: begin
					if (gap_bad) begin
						feed_value_restore_fail_alarm <= 1'b1;
					end else begin
						std_pos       <= std_pos_data;
						one_cycle_pos <= one_cycle_data;
						feed_pos      <= restored_feed;
						cam_active    <= 1'b1;
					end
				end
				default: begin
					feed_value_restore_fail_alarm <= 1'b1;
				end
			endcase
		end else begin
			if (cam_fall) begin
				cam_active <= 1'b0;
			end
			if (ctrl_tick) begin
				axis_delta <= smooth_delta;
				feed_pos   <= feed_pos + smooth_delta;
			end
			if (cam_active) begin
				one_cycle_pos <= one_cycle_pos + comp_step +
					(ctrl_tick ? smooth_delta : 32'sh0000_0000);
			end
		end
	end

	// Register read port.
	wire [15:0] status_word = (16'h0001 << `STS_CAM_ACTIVE_BIT) * {15'h0000, cam_active}
		| (16'h0001 << `STS_ALARM_BIT) * {15'h0000, feed_value_restore_fail_alarm}
		| (16'h0001 << `STS_ENGAGED_BIT) * {15'h0000, coupler_engaged_flag}
		| (16'h0001 << `STS_SMOOTHING_BIT) * {15'h0000, coupler_smoothing_flag}
		| (16'h0001 << `STS_COMP_DONE_BIT) * {15'h0000, comp_done_flag};

	always @(posedge clock) begin
		if (rst) begin
			reg_rdata <= 16'h0000;
		end else if (reg_re) begin
			case (reg_addr)
				`REG_HOST_COMMAND_WORD: reg_rdata <= cmd_q;
				`REG_DRIVE_STATUS_WORD: reg_rdata <= status_word;
				default:                reg_rdata <= 16'h0000;
			endcase
		end
	end

endmodule // cam_restore_clutch_compensation

`default_nettype wire

// ---- tb/crcc_chk.sv ----
`default_nettype none
module crcc_chk (
	// Clock and reset
	input wire logic               clock,
	input wire logic               rst,
	// Register port
	input wire logic [15:0]        reg_addr,
	input wire logic [15:0]        reg_wdata,
	input wire logic               reg_we,
	input wire logic               reg_re,
	input wire logic [15:0]        reg_rdata,
	// Pins and data
	input wire logic               cam_ctrl_cmd,
	input wire logic [1:0]         restore_target,
	input wire logic signed [31:0] std_pos_data,
	input wire logic signed [31:0] one_cycle_data,
	// Outputs
	input wire logic signed [31:0] feed_pos,
	input wire logic signed [31:0] one_cycle_pos,
	input wire logic signed [31:0] std_pos,
	input wire logic signed [31:0] axis_delta,
	input wire logic               cam_active,
	input wire logic               feed_value_restore_fail_alarm,
	input wire logic               coupler_engaged_flag,
	input wire logic               coupler_smoothing_flag,
	input wire logic               comp_done_flag
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	// Only a rising request bit starts compensation, so its last value is kept.
	logic cmd13_q;
	always @(posedge clock) begin
		if (rst)
			cmd13_q <= 1'b0;
		else if (reg_we && reg_addr == 16'h2d02)
			cmd13_q <= reg_wdata[13];
	end
	chk_status_map: assert property (
		reg_re && reg_addr == 16'h2d12 |=> {reg_rdata[13:11], reg_rdata[1:0]} ==
		$past({comp_done_flag, coupler_smoothing_flag, coupler_engaged_flag,
		feed_value_restore_fail_alarm, cam_active}))
		else $error("status word differs from flags");
	chk_unmapped_zero: assert property (
		reg_re && reg_addr != 16'h2d02 && reg_addr != 16'h2d12 |=> reg_rdata == 16'h0000)
		else $error("unmapped read not zero");
	chk_alarm_blocks: assert property (
		feed_value_restore_fail_alarm |-> !cam_active)
		else $error("cam active with alarm");
	chk_cam_enter: assert property (
		$rose(cam_ctrl_cmd) |-> ##[2:5] (cam_active || feed_value_restore_fail_alarm))
		else $error("cam command rise not answered");
	chk_cam_leave: assert property (
		$fell(cam_ctrl_cmd) |-> ##[2:5] !cam_active)
		else $error("cam command fall not answered");
	chk_cam_relation: assert property (
		$rose(cam_active) |-> feed_pos == std_pos + one_cycle_pos)
		else $error("positions inconsistent at entry");
	chk_std_restore: assert property (
		$rose(cam_active) && restore_target == 2'h1 |-> one_cycle_pos == one_cycle_data)
		else $error("one cycle value not taken from data");
	chk_feed_restore: assert property (
		$rose(cam_active) && restore_target == 2'h2 |->
		feed_pos == std_pos_data + one_cycle_data)
		else $error("feed value not restored");
	chk_comp_clears: assert property (
		reg_we && reg_addr == 16'h2d02 && reg_wdata[13] && !cmd13_q && cam_active
		|-> ##[1:3] !comp_done_flag)
		else $error("done not cleared by new request");
	// Cycles since the coupler was last engaged or smoothing; the output
	// increment lags the smoother by one control cycle.
	logic [12:0] idle_q;
	always @(posedge clock) begin
		if (rst || coupler_engaged_flag || coupler_smoothing_flag)
			idle_q <= 13'h0000;
		else if (idle_q != 13'h1fff)
			idle_q <= idle_q + 13'h0001;
	end
	chk_coupler_blocks: assert property (
		idle_q > 13'h1004 |-> axis_delta == 0)
		else $error("pulses passed while disengaged");
	cov_cam_on: cover property ($rose(cam_active));
	cov_alarm: cover property ($rose(feed_value_restore_fail_alarm));
	cov_smooth: cover property ($rose(coupler_smoothing_flag));
	cov_comp: cover property ($rose(comp_done_flag));
endmodule // crcc_chk
bind cam_restore_clutch_compensation crcc_chk chk_u (.*);
`default_nettype wire

// ---- tb/host_model.sv ----
`default_nettype none
module host_model (
	// Clock
	input  wire logic        clock,
	// Register port
	output var  logic [15:0] reg_addr,
	output var  logic [15:0] reg_wdata,
	output var  logic        reg_we,
	output var  logic        reg_re,
	input  wire logic [15:0] reg_rdata,
	// Pins
	output var  logic        cam_ctrl_cmd,
	output var  logic        main_shaft_coupler_cmd,
	output var  logic        ms_pulse,
	output var  logic        ms_dir
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		{reg_addr, reg_wdata, reg_we, reg_re} = '0;
		{cam_ctrl_cmd, main_shaft_coupler_cmd, ms_pulse, ms_dir} = '0;
	end
	// Released lines show the inverse so that no stale value looks valid.
	task automatic acc(input logic [15:0] a, input logic [15:0] d, input logic w);
		@(posedge clock);
		#1;
		reg_addr = a;
		reg_wdata = d;
		reg_we = w;
		reg_re = !w;
		@(posedge clock);
		#1;
		{reg_we, reg_re} = 2'b00;
		reg_addr = ~a;
		reg_wdata = ~d;
	endtask
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		acc(a, d, 1'b1);
	endtask
	task automatic rd(input logic [15:0] a, output logic [31:0] d);
		acc(a, 16'h0000, 1'b0);
		d = {16'h0000, reg_rdata};
	endtask
	task automatic cmd(input logic clutch, input logic comp);
		wr(16'h2d02, {2'b00, comp, 1'b0, clutch, 11'h000});
	endtask
	task automatic cam(input logic v);
		@(posedge clock);
		#1;
		cam_ctrl_cmd = v;
	endtask
	task automatic pulses(input int n);
		repeat (2 * n) begin
			repeat (2) @(posedge clock);
			#1;
			ms_pulse = !ms_pulse;
		end
	endtask
endmodule // host_model
`default_nettype wire

// ---- tb/cam_restore_clutch_compensation_tb_top.sv ----
`default_nettype none
module cam_restore_clutch_compensation_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock = 1'b0;
	logic rst = 1'b1;
	wire [15:0] reg_addr, reg_wdata, reg_rdata;
	wire reg_we, reg_re, cam_ctrl_cmd, main_shaft_coupler_cmd, ms_pulse, ms_dir;
	wire signed [31:0] feed_pos, one_cycle_pos, std_pos, axis_delta;
	wire cam_active, feed_value_restore_fail_alarm, coupler_engaged_flag;
	wire coupler_smoothing_flag, comp_done_flag;
	logic [1:0] restore_target = 2'h1;
	logic signed [31:0] std_pos_data = 32'h0000_0000;
	logic signed [31:0] one_cycle_data = 32'h0000_0064;
	logic signed [31:0] comp_target = 32'h0000_0100;
	logic [31:0] inposition_range_setting = 32'h0000_0064;
	logic coupler_mode_set = 1'b1;
	logic smoothing_system = 1'b1;
	logic [3:0] coupler_tc_shift = 4'h1;
	logic [3:0] comp_tc_shift = 4'h1;
	logic [31:0] rv;
	int n;
	int err_total = 0;
	int total_checks = 0;
	cam_restore_clutch_compensation dut_u (.*);
	host_model host_u (.*);
	always #5 clock = ~clock;
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic complete_run;
		if (err_total == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge clock);
		#1;
	endtask
	task automatic camsw(input logic v);
		host_u.cam(v);
		cyc(8);
	endtask
	initial begin
		cyc(100000);
		err_total++;
		complete_run;
	end
	initial begin
		cyc(3);
		rst = 1'b0;
		// The coupler setting starts as none, so engaged shows until the first DI scan.
		host_u.rd(16'h2d12, rv);
		check(rv, 32'h0000_0800);
		host_u.wr(16'h2d12, 16'hffff);
		host_u.rd(16'h2d02, rv);
		check(rv, 32'h0000_0000);
		host_u.rd(16'h2d12, rv);
		check(rv, 32'h0000_0800);
		host_u.rd(16'h2d04, rv);
		check(rv, 32'h0000_0000);
		camsw(1'b1);
		check(32'(cam_active), 32'h0000_0001);
		check(std_pos, 32'hffff_ff9c);
		camsw(1'b0);
		restore_target = 2'h2;
		std_pos_data = 32'h0000_0032;
		one_cycle_data = 32'h0000_001e;
		camsw(1'b1);
		check(feed_pos, 32'h0000_0050);
		camsw(1'b0);
		std_pos_data = 32'h0000_01f4;
		camsw(1'b1);
		check(32'(feed_value_restore_fail_alarm), 32'h0000_0001);
		check(32'(cam_active), 32'h0000_0000);
		check(feed_pos, 32'h0000_0050);
		camsw(1'b0);
		// A gap equal to the range is still accepted.
		std_pos_data = 32'h0000_0096;
		camsw(1'b1);
		check(32'(cam_active), 32'h0000_0001);
		check(feed_pos, 32'h0000_00b4);
		camsw(1'b0);
		restore_target = 2'h0;
		std_pos_data = 32'h0000_0014;
		camsw(1'b1);
		check(one_cycle_pos, 32'h0000_00a0);
		host_u.cmd(1'b1, 1'b0);
		cyc(8200);
		host_u.rd(16'h2d12, rv);
		check(rv, 32'h0000_0801);
		host_u.pulses(12);
		cyc(2100);
		check(32'(coupler_smoothing_flag), 32'h0000_0001);
		for (n = 0; n < 20000 && coupler_smoothing_flag !== 1'b0; n++)
			cyc(1);
		check(32'(n < 20000), 32'h0000_0001);
		// The last smoothed step reaches the position one control cycle later.
		cyc(2100);
		check(feed_pos, 32'h0000_00c0);
		host_u.cmd(1'b0, 1'b0);
		for (n = 0; n < 8200 && coupler_engaged_flag !== 1'b0; n++)
			cyc(1);
		check(32'(coupler_engaged_flag), 32'h0000_0000);
		// Just after a DI scan: on and off both land before the next one.
		host_u.cmd(1'b1, 1'b0);
		host_u.cmd(1'b0, 1'b0);
		n = 0;
		repeat (4100) begin
			rv[0] = coupler_engaged_flag;
			cyc(1);
			if (coupler_engaged_flag === 1'b1 && rv[0] === 1'b0)
				n++;
		end
		check(32'(n), 32'h0000_0001);
		check(32'(coupler_engaged_flag), 32'h0000_0000);
		host_u.pulses(5);
		cyc(4200);
		check(feed_pos, 32'h0000_00c0);
		host_u.cmd(1'b0, 1'b1);
		for (n = 0; n < 20000 && comp_done_flag !== 1'b1; n++)
			cyc(1);
		check(32'(n < 20000), 32'h0000_0001);
		check(32'(n >= 1990), 32'h0000_0001);
		check(one_cycle_pos, comp_target);
		host_u.rd(16'h2d12, rv);
		check(rv, 32'h0000_2001);
		host_u.cmd(1'b0, 1'b0);
		coupler_mode_set = 1'b0;
		cyc(8200);
		check(32'(coupler_engaged_flag), 32'h0000_0000);
		camsw(1'b0);
		cyc(8200);
		check(32'(coupler_engaged_flag), 32'h0000_0001);
		complete_run;
	end
endmodule // cam_restore_clutch_compensation_tb_top
`default_nettype wire
